// [loe_exec.v]
`timescale 1ns/1ps
`default_nettype none
`include "loe_defs.vh"
module loe_exec #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire start,
    input wire [7:0] opcode,
    input wire [7:0] modrm,
    input wire [15:0] imm_data,
    input wire [WIDTH-1:0] acc_full_word,
    input wire [WIDTH-1:0] reg_a,
    input wire [WIDTH-1:0] reg_b,
    input wire [WIDTH-1:0] mem_rdata,
    input wire wide_bus,
    input wire odd_addr,
    output reg busy_q,
    output reg done_q,
    output reg illegal_q,
    output reg [WIDTH-1:0] result_q,
    output reg [2:0] dest_reg_q,
    output reg wr_acc_q,
    output reg wr_reg_q,
    output reg wr_mem_q,
    output reg size_word_q,
    output reg [2:0] instr_len_q,
    output reg [1:0] xfer_cnt_q,
    output reg arith_wrap_flag,
    output reg carry_out_flag,
    output reg top_bit_flag,
    output reg result_nil_flag,
    output reg even_ones_flag,
    output reg nibble_carry_flag
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    reg [1:0] state_q;
    reg [4:0] cnt_q;
    reg [1:0] op_d;
    reg [2:0] form_d;
    reg legal_d;
    reg [WIDTH-1:0] a_d;
    reg [WIDTH-1:0] b_d;
    reg [WIDTH-1:0] res_d;
    reg [4:0] clocks_d;
    reg [1:0] xfer_d;
    reg [2:0] len_d;
    reg [2:0] disp_len;
    reg [WIDTH-1:0] result_pend_q;
    reg [2:0] dest_kind_q;
    reg [2:0] dest_sel_d;
    reg [WIDTH-1:0] imm_ext;
    wire w_bit;
    wire slow_word;
    wire [1:0] mod_f;
    wire [2:0] sub_f;
    wire f_top;
    wire f_nil;
    wire f_even;

    assign w_bit = opcode[0];
    assign mod_f = modrm[7:6];
    assign sub_f = modrm[5:3];
    // Word at odd address or on narrow bus needs two bus cycles
    assign slow_word = w_bit & (~wide_bus | odd_addr);

    always @* begin
        op_d = `LOE_OP_AND;
        form_d = `LOE_FORM_ACC_IMM;
        legal_d = 1'b1;
        case ({opcode[7:1], 1'b0})
            `LOE_OPC_AND_ACC: begin
                op_d = `LOE_OP_AND;
                form_d = `LOE_FORM_ACC_IMM;
            end
            `LOE_OPC_OR_ACC: begin
                op_d = `LOE_OP_OR;
                form_d = `LOE_FORM_ACC_IMM;
            end
            `LOE_OPC_OR_RR, `LOE_OPC_XOR_RR: begin
                op_d = (opcode[5]) ? `LOE_OP_XOR : `LOE_OP_OR;
                form_d = (mod_f == `LOE_MODRM_REG) ? `LOE_FORM_REG_REG :
                    `LOE_FORM_REG_MEM;
            end
            `LOE_OPC_OR_MR, `LOE_OPC_XOR_MR: begin
                op_d = (opcode[5]) ? `LOE_OP_XOR : `LOE_OP_OR;
                form_d = (mod_f == `LOE_MODRM_REG) ? `LOE_FORM_REG_REG :
                    `LOE_FORM_MEM_REG;
            end
            `LOE_OPC_GRP_IMM: begin
                if (sub_f == `LOE_SUB_OR) begin
                    op_d = `LOE_OP_OR;
                end else if (sub_f == `LOE_SUB_XOR) begin
                    op_d = `LOE_OP_XOR;
                end else begin
                    legal_d = 1'b0;
                end
                form_d = (mod_f == `LOE_MODRM_REG) ? `LOE_FORM_REG_IMM :
                    `LOE_FORM_MEM_IMM;
            end
            // Anything else is refused with a one-cycle illegal pulse
            default: legal_d = 1'b0;
        endcase
    end

    always @* begin
        case (mod_f)
            2'h1: disp_len = 3'h1;
            2'h2: disp_len = 3'h2;
            2'h0: disp_len = (modrm[2:0] == 3'h6) ? 3'h2 : 3'h0;
            default: disp_len = 3'h0;
        endcase
    end

    // Immediate zero-extended to the datapath width
    always @* begin
        imm_ext = {WIDTH{1'b0}};
        imm_ext[15:0] = imm_data;
    end

    // Direction bit says which field names the first operand
    always @* begin
        case (form_d)
            `LOE_FORM_REG_IMM: dest_sel_d = modrm[2:0];
            `LOE_FORM_REG_REG: dest_sel_d = opcode[1] ? modrm[5:3] : modrm[2:0];
            default: dest_sel_d = modrm[5:3];
        endcase
    end

    always @* begin
        a_d = reg_a;
        b_d = reg_b;
        clocks_d = `LOE_CLK_IMM;
        xfer_d = `LOE_XFER_NONE;
        len_d = 3'h2;
        case (form_d)
            `LOE_FORM_ACC_IMM: begin
                a_d = acc_full_word;
                b_d = imm_ext;
                clocks_d = `LOE_CLK_IMM;
                len_d = w_bit ? 3'h3 : 3'h2;
            end
            `LOE_FORM_REG_REG: begin
                clocks_d = `LOE_CLK_REG_REG;
                len_d = 3'h2;
            end
            `LOE_FORM_MEM_REG: begin
                a_d = mem_rdata;
                clocks_d = slow_word ? `LOE_CLK_MEM_REG_SLOW : `LOE_CLK_MEM_REG_FAST;
                xfer_d = `LOE_XFER_TWO;
                len_d = 3'h2 + disp_len;
            end
            `LOE_FORM_REG_MEM: begin
                b_d = mem_rdata;
                clocks_d = slow_word ? `LOE_CLK_REG_MEM_SLOW : `LOE_CLK_REG_MEM_FAST;
                xfer_d = `LOE_XFER_ONE;
                len_d = 3'h2 + disp_len;
            end
            `LOE_FORM_REG_IMM: begin
                b_d = imm_ext;
                clocks_d = `LOE_CLK_IMM;
                len_d = w_bit ? 3'h4 : 3'h3;
            end
            `LOE_FORM_MEM_IMM: begin
                a_d = mem_rdata;
                b_d = imm_ext;
                clocks_d = slow_word ? `LOE_CLK_MEM_IMM_SLOW : `LOE_CLK_MEM_IMM_FAST;
                xfer_d = `LOE_XFER_TWO;
                len_d = (w_bit ? 3'h4 : 3'h3) + disp_len;
            end
            default: begin
                clocks_d = `LOE_CLK_IMM;
            end
        endcase
        if (!w_bit) begin
            b_d = {{(WIDTH-8){1'b0}}, b_d[7:0]};
        end
        case (op_d)
            `LOE_OP_AND: res_d = a_d & b_d;
            `LOE_OP_OR: res_d = a_d | b_d;
            default: res_d = a_d ^ b_d;
        endcase
        // Byte ops leave the high byte of the destination unchanged
        if (!w_bit) begin
            res_d = {a_d[WIDTH-1:8], res_d[7:0]};
        end
    end

    loe_flags #(
        .WIDTH(WIDTH)
    ) u_flags (
        .result(result_pend_q),
        .size_word(size_word_q),
        .top_bit(f_top),
        .nil(f_nil),
        .even_ones(f_even)
    );

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            illegal_q <= 1'b0;
            result_q <= {WIDTH{1'b0}};
            result_pend_q <= {WIDTH{1'b0}};
            dest_reg_q <= 3'h0;
            dest_kind_q <= 3'h0;
            wr_acc_q <= 1'b0;
            wr_reg_q <= 1'b0;
            wr_mem_q <= 1'b0;
            size_word_q <= 1'b0;
            instr_len_q <= 3'h0;
            xfer_cnt_q <= 2'h0;
            arith_wrap_flag <= 1'b0;
            carry_out_flag <= 1'b0;
            top_bit_flag <= 1'b0;
            result_nil_flag <= 1'b0;
            even_ones_flag <= 1'b0;
            nibble_carry_flag <= 1'b0;
        end else if (clk_en) begin
            done_q <= 1'b0;
            wr_acc_q <= 1'b0;
            wr_reg_q <= 1'b0;
            wr_mem_q <= 1'b0;
            illegal_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start && legal_d) begin
                        state_q <= ST_RUN;
                        busy_q <= 1'b1;
                        // Counter ends on the last clock of the instruction
                        cnt_q <= clocks_d - 5'h01;
                        result_pend_q <= res_d;
                        size_word_q <= w_bit;
                        instr_len_q <= len_d;
                        xfer_cnt_q <= xfer_d;
                        dest_reg_q <= dest_sel_d;
                        wr_acc_q <= 1'b0;
                        if (cnt_q == 5'h00) begin
                            wr_acc_q <= 1'b0;
                        end
                        wr_mem_q <= 1'b0;
                        result_q <= result_q;
                        dest_kind_q <= form_d;
                    end else if (start) begin
                        illegal_q <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (cnt_q <= 5'h01) begin
                        state_q <= ST_IDLE;
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        result_q <= result_pend_q;
                        wr_acc_q <= (dest_kind_q == `LOE_FORM_ACC_IMM);
                        wr_mem_q <= (dest_kind_q == `LOE_FORM_MEM_REG) ||
                            (dest_kind_q == `LOE_FORM_MEM_IMM);
                        wr_reg_q <= (dest_kind_q == `LOE_FORM_REG_REG) ||
                            (dest_kind_q == `LOE_FORM_REG_MEM) ||
                            (dest_kind_q == `LOE_FORM_REG_IMM);
                        // Flags keep their last value between instructions
                        arith_wrap_flag <= 1'b0;
                        carry_out_flag <= 1'b0;
                        top_bit_flag <= f_top;
                        result_nil_flag <= f_nil;
                        even_ones_flag <= f_even;
                        // Left undefined by the instruction; held at zero here
                        nibble_carry_flag <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [loe_defs.vh]
`ifndef LOE_DEFS_VH
`define LOE_DEFS_VH
// Operation select
`define LOE_OP_AND 2'h0
`define LOE_OP_OR 2'h1
`define LOE_OP_XOR 2'h2
// Operand forms
`define LOE_FORM_ACC_IMM 3'h0
`define LOE_FORM_REG_REG 3'h1
`define LOE_FORM_MEM_REG 3'h2
`define LOE_FORM_REG_MEM 3'h3
`define LOE_FORM_REG_IMM 3'h4
`define LOE_FORM_MEM_IMM 3'h5
// Clock counts
`define LOE_CLK_REG_REG 5'h02
`define LOE_CLK_IMM 5'h04
`define LOE_CLK_REG_MEM_FAST 5'h0b
`define LOE_CLK_REG_MEM_SLOW 5'h0f
`define LOE_CLK_MEM_REG_FAST 5'h10
`define LOE_CLK_MEM_REG_SLOW 5'h18
`define LOE_CLK_MEM_IMM_FAST 5'h12
`define LOE_CLK_MEM_IMM_SLOW 5'h1a
// Transfers
`define LOE_XFER_NONE 2'h0
`define LOE_XFER_ONE 2'h1
`define LOE_XFER_TWO 2'h2
// Opcode patterns (first byte, size bit masked) and ModRM field codes
`define LOE_OPC_AND_ACC 8'h24
`define LOE_OPC_OR_RR 8'h0a
`define LOE_OPC_OR_MR 8'h08
`define LOE_OPC_OR_ACC 8'h0c
`define LOE_OPC_XOR_RR 8'h32
`define LOE_OPC_XOR_MR 8'h30
`define LOE_OPC_GRP_IMM 8'h80
`define LOE_MODRM_REG 2'h3
`define LOE_SUB_OR 3'h1
`define LOE_SUB_XOR 3'h6
`endif

// [loe_flags.v]
`timescale 1ns/1ps
`default_nettype none
`include "loe_defs.vh"
module loe_flags #(
    parameter WIDTH = 16
) (
    input wire [WIDTH-1:0] result,
    input wire size_word,
    output wire top_bit,
    output wire nil,
    output wire even_ones
);
    wire [7:0] low_byte;
    assign low_byte = result[7:0];
    assign top_bit = size_word ? result[WIDTH-1] : result[7];
    assign nil = size_word ? (result == {WIDTH{1'b0}}) : (low_byte == 8'h00);
    // Parity covers only the low byte, as on the flag register
    assign even_ones = ~(^low_byte);
endmodule
`default_nettype wire

// [loe_exec_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module loe_exec_checker #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] modrm,
    input wire logic busy_q,
    input wire logic done_q,
    input wire logic [WIDTH-1:0] result_q,
    input wire logic size_word_q,
    input wire logic [2:0] instr_len_q,
    input wire logic [1:0] xfer_cnt_q,
    input wire logic wr_acc_q,
    input wire logic wr_mem_q,
    input wire logic arith_wrap_flag,
    input wire logic carry_out_flag,
    input wire logic top_bit_flag,
    input wire logic result_nil_flag,
    input wire logic even_ones_flag
);
    wire go = start && !busy_q && clk_en;
    wire accf = opcode[7:1] == 7'h12 || opcode[7:1] == 7'h06;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_flag_clr;
        !(arith_wrap_flag || carry_out_flag);
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("wrap or carry set");
    property p_nil;
        done_q |-> result_nil_flag == (size_word_q ? result_q == 16'h0000 : result_q[7:0] == 8'h00);
    endproperty
    a_nil: assert property (p_nil) else $error("zero flag");
    property p_par;
        done_q |-> even_ones_flag == ~^result_q[7:0];
    endproperty
    a_par: assert property (p_par) else $error("parity flag");
    property p_top;
        done_q |-> top_bit_flag == (size_word_q ? result_q[WIDTH-1] : result_q[7]);
    endproperty
    a_top: assert property (p_top) else $error("sign flag");
    property p_rr;
        go && modrm[7:6] == 2'h3 && (opcode[7:1] == 7'h05 || opcode[7:1] == 7'h19) |-> ##2 done_q;
    endproperty
    a_rr: assert property (p_rr) else $error("reg pair timing");
    property p_acc;
        go && accf |-> ##4 done_q && wr_acc_q;
    endproperty
    a_acc: assert property (p_acc) else $error("acc timing");
    property p_len;
        go && accf |=> instr_len_q == 3'h2 + {2'h0, $past(opcode[0])};
    endproperty
    a_len: assert property (p_len) else $error("acc length");
    property p_memx;
        wr_mem_q |-> done_q && xfer_cnt_q == 2'h2;
    endproperty
    a_memx: assert property (p_memx) else $error("mem transfers");
    property p_mr16;
        go && opcode == 8'h08 && modrm[7:6] != 2'h3 |-> ##1 !done_q [*8] ##8 done_q;
    endproperty
    a_mr16: assert property (p_mr16) else $error("mem byte timing");
endmodule
`default_nettype wire

// [loe_exec_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module loe_exec_tb;
    logic clk, rst_n, clk_en, start, wide_bus, odd_addr, busy_q, done_q, illegal_q;
    logic wr_acc_q, wr_reg_q, wr_mem_q, size_word_q, arith_wrap_flag, carry_out_flag;
    logic top_bit_flag, result_nil_flag, even_ones_flag, nibble_carry_flag;
    logic [7:0] opcode, modrm;
    logic [15:0] imm_data, acc_full_word, reg_a, reg_b, mem_rdata, result_q;
    logic [2:0] dest_reg_q, instr_len_q;
    logic [1:0] xfer_cnt_q;
    int err_count = 0;
    int checks = 0;
    loe_exec u_dut (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .start(start),
        .opcode(opcode),
        .modrm(modrm),
        .imm_data(imm_data),
        .acc_full_word(acc_full_word),
        .reg_a(reg_a),
        .reg_b(reg_b),
        .mem_rdata(mem_rdata),
        .wide_bus(wide_bus),
        .odd_addr(odd_addr),
        .busy_q(busy_q),
        .done_q(done_q),
        .illegal_q(illegal_q),
        .result_q(result_q),
        .dest_reg_q(dest_reg_q),
        .wr_acc_q(wr_acc_q),
        .wr_reg_q(wr_reg_q),
        .wr_mem_q(wr_mem_q),
        .size_word_q(size_word_q),
        .instr_len_q(instr_len_q),
        .xfer_cnt_q(xfer_cnt_q),
        .arith_wrap_flag(arith_wrap_flag),
        .carry_out_flag(carry_out_flag),
        .top_bit_flag(top_bit_flag),
        .result_nil_flag(result_nil_flag),
        .even_ones_flag(even_ones_flag),
        .nibble_carry_flag(nibble_carry_flag)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_n(input int got, input int exp);
        checks++;
        if (got != exp) begin
            err_count++;
            $display("wrong value at %0t: cycles %0d want %0d", $time, got, exp);
        end
    endtask
    // a is the first operand, b the second; memory-immediate takes memory from a
    task automatic run(input logic [7:0] op, input logic [7:0] mr, input logic [15:0] a,
            input logic [15:0] b, input logic [1:0] bo, input int n, input logic [15:0] res,
            input logic [2:0] sel, input logic [2:0] dst, input logic [2:0] len,
            input logic [1:0] xf);
        int k;
        logic [15:0] m;
        logic [4:0] f;
        logic [4:0] g;
        m = op[0] ? 16'hffff : 16'h00ff;
        {opcode, modrm, acc_full_word, reg_a, imm_data, reg_b} <= {op, mr, a, a, b, b};
        // Memory is the first operand unless the direction bit names a register
        mem_rdata <= op[1] ? b : a;
        {wide_bus, odd_addr, start} <= {bo, 1'b1};
        @(posedge clk);
        start <= 1'b0;
        #1;
        cmp_v(16'(instr_len_q), 16'(len));
        cmp_v(16'(xfer_cnt_q), 16'(xf));
        cmp_v(16'(size_word_q), 16'(op[0]));
        k = 1;
        while (done_q !== 1'b1) begin
            if (k > 30) begin
                err_count++;
                complete_run;
            end
            @(posedge clk);
            #1;
            k++;
        end
        cmp_n(k, n);
        cmp_v(result_q & m, res);
        f = {2'b00, (op[0] ? res[15] : res[7]), (res == 16'h0000), ~^res[7:0]};
        g = {arith_wrap_flag, carry_out_flag, top_bit_flag, result_nil_flag, even_ones_flag};
        cmp_v(16'(g), 16'(f));
        cmp_v(16'({wr_acc_q, wr_reg_q, wr_mem_q}), 16'(sel));
        if (sel == 3'h2) cmp_v(16'(dest_reg_q), 16'(dst));
        @(posedge clk);
    endtask
    task automatic t_acc;
        run(8'h24, 8'h00, 16'ha5c3, 16'h0f3c, 2'h2, 4, 16'h0000, 3'h4, 3'h0, 3'h2, 2'h0);
        run(8'h25, 8'h00, 16'hc3c3, 16'h8001, 2'h0, 4, 16'h8001, 3'h4, 3'h0, 3'h3, 2'h0);
        run(8'h0c, 8'h00, 16'h1200, 16'h0034, 2'h1, 4, 16'h0034, 3'h4, 3'h0, 3'h2, 2'h0);
        run(8'h0d, 8'h00, 16'h1200, 16'h0001, 2'h3, 4, 16'h1201, 3'h4, 3'h0, 3'h3, 2'h0);
    endtask
    task automatic t_rr;
        run(8'h0a, 8'hc1, 16'h0050, 16'h0003, 2'h0, 2, 16'h0053, 3'h2, 3'h0, 3'h2, 2'h0);
        run(8'h0b, 8'hd8, 16'h1000, 16'h0101, 2'h1, 2, 16'h1101, 3'h2, 3'h3, 3'h2, 2'h0);
        run(8'h32, 8'hc9, 16'h00ff, 16'h00ff, 2'h2, 2, 16'h0000, 3'h2, 3'h1, 3'h2, 2'h0);
        run(8'h33, 8'hf2, 16'haaaa, 16'hffff, 2'h3, 2, 16'h5555, 3'h2, 3'h6, 3'h2, 2'h0);
    endtask
    task automatic t_mem;
        run(8'h08, 8'h47, 16'h0022, 16'h0011, 2'h2, 16, 16'h0033, 3'h1, 3'h0, 3'h3, 2'h2);
        run(8'h09, 8'h47, 16'h00f0, 16'h0f00, 2'h0, 24, 16'h0ff0, 3'h1, 3'h0, 3'h3, 2'h2);
        run(8'h31, 8'h47, 16'h0f0f, 16'hffff, 2'h3, 24, 16'hf0f0, 3'h1, 3'h0, 3'h3, 2'h2);
        run(8'h31, 8'h47, 16'h0f0f, 16'hffff, 2'h2, 16, 16'hf0f0, 3'h1, 3'h0, 3'h3, 2'h2);
        run(8'h0a, 8'h47, 16'h0080, 16'h0001, 2'h2, 11, 16'h0081, 3'h2, 3'h0, 3'h3, 2'h1);
        run(8'h0b, 8'h47, 16'h8000, 16'h0001, 2'h0, 15, 16'h8001, 3'h2, 3'h0, 3'h3, 2'h1);
        run(8'h33, 8'h47, 16'h000f, 16'h00ff, 2'h2, 11, 16'h00f0, 3'h2, 3'h0, 3'h3, 2'h1);
    endtask
    task automatic t_imm;
        run(8'h80, 8'hc8, 16'h0010, 16'h0001, 2'h0, 4, 16'h0011, 3'h2, 3'h0, 3'h3, 2'h0);
        run(8'h81, 8'hcb, 16'h0100, 16'h8000, 2'h1, 4, 16'h8100, 3'h2, 3'h3, 3'h4, 2'h0);
        run(8'h80, 8'hf1, 16'h00ff, 16'h000f, 2'h2, 4, 16'h00f0, 3'h2, 3'h1, 3'h3, 2'h0);
        run(8'h81, 8'hf7, 16'hffff, 16'h00ff, 2'h3, 4, 16'hff00, 3'h2, 3'h7, 3'h4, 2'h0);
        run(8'h80, 8'h4f, 16'h0040, 16'h0002, 2'h2, 18, 16'h0042, 3'h1, 3'h0, 3'h4, 2'h2);
        run(8'h81, 8'h77, 16'h4000, 16'h0002, 2'h0, 26, 16'h4002, 3'h1, 3'h0, 3'h5, 2'h2);
        run(8'h81, 8'h77, 16'hffff, 16'h0001, 2'h2, 18, 16'hfffe, 3'h1, 3'h0, 3'h5, 2'h2);
    endtask
    task automatic t_refuse;
        {opcode, start} <= {8'hff, 1'b1};
        @(posedge clk);
        start <= 1'b0;
        #1;
        cmp_v(16'({illegal_q, busy_q}), 16'h0002);
        @(posedge clk);
        // Frozen clock enable must not accept a pending start
        {opcode, modrm, clk_en, start} <= {8'h0a, 8'hc0, 1'b0, 1'b1};
        @(posedge clk);
        {clk_en, start} <= 2'h2;
        #1;
        cmp_v(16'({busy_q, done_q}), 16'h0000);
        @(posedge clk);
    endtask
    initial begin
        {rst_n, clk_en, start, wide_bus, odd_addr} = 5'h08;
        {opcode, modrm} = 16'h0000;
        {imm_data, acc_full_word, reg_a, reg_b, mem_rdata} = 80'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_acc;
        t_rr;
        t_mem;
        t_imm;
        t_refuse;
        complete_run;
    end
endmodule
bind loe_exec loe_exec_checker #(.WIDTH(WIDTH)) u_chk (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(start),
    .opcode(opcode),
    .modrm(modrm),
    .busy_q(busy_q),
    .done_q(done_q),
    .result_q(result_q),
    .size_word_q(size_word_q),
    .instr_len_q(instr_len_q),
    .xfer_cnt_q(xfer_cnt_q),
    .wr_acc_q(wr_acc_q),
    .wr_mem_q(wr_mem_q),
    .arith_wrap_flag(arith_wrap_flag),
    .carry_out_flag(carry_out_flag),
    .top_bit_flag(top_bit_flag),
    .result_nil_flag(result_nil_flag),
    .even_ones_flag(even_ones_flag)
);
`default_nettype wire
